// *** hdl/serirq_host_interrupt_control.sv ***
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "serirq_params.svh"

module serirq_host_interrupt_control
  import serirq_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Link pins
  input  wire logic        lpc_clk,
  input  wire logic        stop_frame,
  input  wire logic        stop_quiet,
  input  wire logic        host_data_read,
  input  wire logic        lpc_hw_reset_n,
  input  wire logic        lpc_sw_reset,
  // Requests toward the host side and the local processor
  output logic             host_smi_req,
  output logic             start_frame_req,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Link sampling

  logic                  link_rise;
  logic [`LINK_PINS-1:0] pins_s;
  logic                  stop_s;
  logic                  quiet_s;
  logic                  hrd_s;
  logic                  hw_n_s;
  logic                  sw_s;
  logic                  lpc_reset;
  logic                  lpc_reset_q;
  logic                  host_rd_evt;
  logic                  mode_evt;

  link_pin_sampler u_sampler (
    .clock     (clock),
    .rstn      (rstn),
    .link_clk  (lpc_clk),
    .pins      ({stop_frame, stop_quiet, host_data_read, lpc_hw_reset_n, lpc_sw_reset}),
    .link_rise (link_rise),
    .pins_sync (pins_s)
  );

  // Split the synchronised pins
  assign {stop_s, quiet_s, hrd_s, hw_n_s, sw_s} = pins_s;
  assign lpc_reset   = ~hw_n_s | sw_s;
  assign host_rd_evt = link_rise & hrd_s;
  assign mode_evt    = link_rise & stop_s;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic      ack;
  logic      wr_ok;
  logic      rd_ok;
  logic      ctrl_wr;
  logic      ctrl_rd;
  logic      stat_wr;
  logic      odr_wr;
  logic      twr_wr;
  logic      iclr_wr;
  logic      ien_wr;
  reg_byte_t wd;

  // Every access answers in the cycle after it is seen
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ack <= 1'b0;
    else
      ack <= (read | write) & ~ack;
  end

  assign waitrequest = (read | write) & ~ack;
  assign wr_ok   = write & ack & byteenable[0];
  assign rd_ok   = read & ack;
  assign wd      = writedata[7:0];
  assign ctrl_wr = wr_ok & (address == `OFF_CTRL0);
  assign ctrl_rd = rd_ok & (address == `OFF_CTRL0);
  assign stat_wr = wr_ok & (address == `OFF_STATUS3);
  assign odr_wr  = wr_ok & (address == `OFF_ODATA3);
  assign twr_wr  = wr_ok & (address == `OFF_TWOWAY15);
  assign ien_wr  = wr_ok & (address == `OFF_IRQ_EN);
  assign iclr_wr = wr_ok & (address == `OFF_IRQ_CLR);

  ////////////////////////////////////////////////////////////////////////////
  // Control and flags

  logic      quiet;
  logic      start_request_select;
  logic      direct_enable_mode;
  logic      smi_enable_ch3_a;
  logic      smi_enable_ch3_b;
  logic      arm_a;
  logic      arm_b;
  logic      out_full_ch3_a;
  logic      out_full_ch3_b;
  logic      clr_a;
  logic      clr_b;
  reg_byte_t output_data_ch3;
  reg_byte_t two_way_last_byte;

  // Mode flag follows the stop frame
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      quiet <= 1'b0;
    else if (lpc_reset)
      quiet <= 1'b0;
    else if (mode_evt)
      quiet <= quiet_s;
  end

  // Plain software control bits
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      start_request_select <= 1'(`CTRL0_RESET >> `BIT_SELECT);
      direct_enable_mode   <= 1'(`CTRL0_RESET >> `BIT_DIRECT);
    end
    else if (ctrl_wr)
    begin
      start_request_select <= wd[`BIT_SELECT];
      direct_enable_mode   <= wd[`BIT_DIRECT];
    end
  end

  // Data bytes written toward the host
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      output_data_ch3   <= `DATA_RESET;
      two_way_last_byte <= `DATA_RESET;
    end
    else
    begin
      if (odr_wr)
        output_data_ch3 <= wd;
      if (twr_wr)
        two_way_last_byte <= wd;
    end
  end

  // Flag clears that really drop a set flag; a same-cycle set wins
  assign clr_a = out_full_ch3_a & ~odr_wr & (host_rd_evt | (stat_wr & ~wd[`BIT_FULL_A]));
  assign clr_b = out_full_ch3_b & ~twr_wr & stat_wr & ~wd[`BIT_FULL_B];

  // Output buffer full flags
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      out_full_ch3_a <= 1'b0;
      out_full_ch3_b <= 1'b0;
    end
    else
    begin
      if (odr_wr)
        out_full_ch3_a <= 1'b1;
      else if (clr_a)
        out_full_ch3_a <= 1'b0;
      if (twr_wr)
        out_full_ch3_b <= 1'b1;
      else if (clr_b)
        out_full_ch3_b <= 1'b0;
    end
  end

  // Arming: a read showing the enable at 0 allows one later write of 1
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      arm_a <= 1'b0;
      arm_b <= 1'b0;
    end
    else
    begin
      if (ctrl_rd)
        arm_a <= ~smi_enable_ch3_a;
      else if (ctrl_wr)
        arm_a <= 1'b0;
      if (ctrl_rd)
        arm_b <= ~smi_enable_ch3_b;
      else if (ctrl_wr)
        arm_b <= 1'b0;
    end
  end

  // SMI enable a
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      smi_enable_ch3_a <= 1'b0;
    else if (lpc_reset)
      smi_enable_ch3_a <= 1'b0;
    else if (clr_a & ~direct_enable_mode)
      smi_enable_ch3_a <= 1'b0;
    else if (ctrl_wr & ~wd[`BIT_SMIE_A])
      smi_enable_ch3_a <= 1'b0;
    else if (ctrl_wr & arm_a)
      smi_enable_ch3_a <= 1'b1;
  end

  // SMI enable b
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      smi_enable_ch3_b <= 1'b0;
    else if (lpc_reset)
      smi_enable_ch3_b <= 1'b0;
    else if (clr_b & ~direct_enable_mode)
      smi_enable_ch3_b <= 1'b0;
    else if (ctrl_wr & ~wd[`BIT_SMIE_B])
      smi_enable_ch3_b <= 1'b0;
    else if (ctrl_wr & arm_b)
      smi_enable_ch3_b <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host requests and start frame

  req_pair_t req;
  req_pair_t pend;
  logic      next_start;

  // Direct mode bypasses the channel 3 buffer-full gating, and also keeps each enable when its flag clears
  assign req[0] = smi_enable_ch3_a & (direct_enable_mode | out_full_ch3_a);
  assign req[1] = smi_enable_ch3_b & (direct_enable_mode | out_full_ch3_b);

  // Start frame wanted on all-clear or any-clear, quiet mode only
  assign next_start = quiet & (start_request_select ? |(pend & ~req)
                                                    : (|pend & ~|req));

  // Registered requests
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pend            <= '0;
      host_smi_req    <= 1'b0;
      start_frame_req <= 1'b0;
    end
    else
    begin
      pend            <= req;
      host_smi_req    <= |req;
      start_frame_req <= next_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local interrupt

  irq_vec_t irq_status;
  irq_vec_t irq_enable;
  irq_vec_t events;

  assign events = {start_frame_req, lpc_reset & ~lpc_reset_q, host_rd_evt, mode_evt};

  // Reset edge finder; starts high because the sampler shows the link
  // reset active just after rstn, which must not count as an event
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      lpc_reset_q <= 1'b1;
    else
      lpc_reset_q <= lpc_reset;
  end

  // Sticky status, a new event beats a clear
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      irq_status <= `IRQ_RESET;
    else if (iclr_wr)
      irq_status <= (irq_status & ~wd[3:0]) | events;
    else
      irq_status <= irq_status | events;
  end

  // Enable register and interrupt line
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_enable <= `IRQ_RESET;
      irq        <= 1'b0;
    end
    else
    begin
      if (ien_wr)
        irq_enable <= wd[3:0];
      irq <= |(irq_status & irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  function automatic reg_byte_t read_mux(input logic [4:0] a);
    reg_byte_t v;
    v = 8'h00;
    unique case (a)
      `OFF_CTRL0:    v = {quiet, start_request_select, direct_enable_mode,
                          smi_enable_ch3_b, smi_enable_ch3_a, 3'h0};
      `OFF_STATUS3:  v = {6'h00, out_full_ch3_b, out_full_ch3_a};
      `OFF_ODATA3:   v = output_data_ch3;
      `OFF_TWOWAY15: v = two_way_last_byte;
      `OFF_IRQ_STAT: v = {4'h0, irq_status};
      `OFF_IRQ_EN:   v = {4'h0, irq_enable};
      default:       v = 8'h00;
    endcase
    return v;
  endfunction

  // Data loaded with the acknowledge, stands in the answer cycle
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      readdata <= 32'h0000_0000;
    else if (read & ~ack)
      readdata <= {24'h00_0000, read_mux(address)};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  lpc_reset_clear_a: assert property (lpc_reset |=> !quiet && !smi_enable_ch3_a && !smi_enable_ch3_b)
    else $error("LPC reset left mode or enable set");
  mode_capture_a: assert property (mode_evt && !lpc_reset |=> quiet == $past(quiet_s))
    else $error("Mode flag missed stop frame value");
  smi_gated_a: assert property (!direct_enable_mode && !out_full_ch3_a && !out_full_ch3_b |=> !host_smi_req)
    else $error("SMI raised without buffer full");
  smi_direct_a: assert property (direct_enable_mode && smi_enable_ch3_a |=> host_smi_req)
    else $error("Direct SMI a not raised");
  smi_twoway_a: assert property (twr_wr && smi_enable_ch3_b && !lpc_reset ##1 smi_enable_ch3_b |=> host_smi_req)
    else $error("Two-way write did not raise SMI");
  enable_a_drop_a: assert property (clr_a && !direct_enable_mode |=> !smi_enable_ch3_a)
    else $error("Enable a survived flag clear");
  enable_b_drop_a: assert property (clr_b && !direct_enable_mode |=> !smi_enable_ch3_b)
    else $error("Enable b survived flag clear");
  set_guard_a: assert property ($rose(smi_enable_ch3_a) |-> $past(arm_a) && $past(ctrl_wr))
    else $error("Enable a set without prior read");
  set_guard_b_a: assert property ($rose(smi_enable_ch3_b) |-> $past(arm_b) && $past(ctrl_wr))
    else $error("Enable b set without prior read");
  flag_set_a: assert property (odr_wr |=> out_full_ch3_a)
    else $error("Output write did not set flag a");
  host_read_a: assert property (host_rd_evt && !odr_wr |=> !out_full_ch3_a)
    else $error("Host read did not clear flag a");
  start_all_a: assert property (quiet && !start_request_select && !lpc_reset && !mode_evt
                                && pend == 2'b11 && req == 2'b01 |=> !start_frame_req)
    else $error("Start frame requested before all cleared");
  start_quiet_a: assert property (start_frame_req |-> $past(quiet))
    else $error("Start frame requested in continuous mode");

  quiet_entry_c: cover property (mode_evt && quiet_s ##1 quiet);
  smi_req_c:     cover property (odr_wr && smi_enable_ch3_a ##2 host_smi_req);
  start_c:       cover property (start_frame_req);
  irq_c:         cover property (irq);

endmodule // serirq_host_interrupt_control

`default_nettype wire

// *** hdl/serirq_params.svh ***
`ifndef SERIRQ_PARAMS_SVH
`define SERIRQ_PARAMS_SVH

// Register byte offsets on the bus
`define OFF_CTRL0     5'h00
`define OFF_STATUS3   5'h04
`define OFF_ODATA3    5'h08
`define OFF_TWOWAY15  5'h0c
`define OFF_IRQ_STAT  5'h10
`define OFF_IRQ_EN    5'h14
`define OFF_IRQ_CLR   5'h18

// Control register 0 field positions
`define BIT_QUIET     7
`define BIT_SELECT    6
`define BIT_DIRECT    5
`define BIT_SMIE_B    4
`define BIT_SMIE_A    3

// Status register 3 field positions
`define BIT_FULL_A    0
`define BIT_FULL_B    1

// Interrupt event positions
`define EV_MODE       0
`define EV_HOST_READ  1
`define EV_LPC_RESET  2
`define EV_START      3

// Reset values
`define CTRL0_RESET   8'h00
`define DATA_RESET    8'h00
`define IRQ_RESET     4'h0

// Link pin count besides the link clock
`define LINK_PINS     5

`endif

// *** hdl/serirq_pkg.sv ***
`default_nettype none

package serirq_pkg;

  // One byte of register content
  typedef logic [7:0] reg_byte_t;

  // Sticky interrupt event vector
  typedef logic [3:0] irq_vec_t;

  // Channel 3 host request pair, bit 0 is source a, bit 1 source b
  typedef logic [1:0] req_pair_t;

endpackage

`default_nettype wire

// *** hdl/link_pin_sampler.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "serirq_params.svh"

module link_pin_sampler
  import serirq_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rstn,
  // Pins from the link
  input  wire logic                    link_clk,
  input  wire logic [`LINK_PINS-1:0]   pins,
  // Synchronised view
  output logic                         link_rise,
  output logic      [`LINK_PINS-1:0]   pins_sync
);

  logic [`LINK_PINS:0] meta;
  logic [`LINK_PINS:0] sync;
  logic                clk_last;

  // Two flip-flop synchroniser for clock and data pins alike
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= '0;
      sync <= '0;
    end
    else
    begin
      meta <= {link_clk, pins};
      sync <= meta;
    end
  end

  // Last synchronised link clock level for edge finding
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      clk_last <= 1'b0;
    else
      clk_last <= sync[`LINK_PINS];
  end

  // Rising link clock edge, data stands aligned with it
  assign link_rise = sync[`LINK_PINS] & ~clk_last;
  assign pins_sync = sync[`LINK_PINS-1:0];

endmodule // link_pin_sampler

`default_nettype wire

// *** tb/host_chipset_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module host_chipset_model
(
  // Clock
  input  wire logic clock,
  // Link pins toward the block
  output var  logic lpc_clk,
  output var  logic stop_frame,
  output var  logic stop_quiet,
  output var  logic host_data_read,
  output var  logic lpc_hw_reset_n,
  output var  logic lpc_sw_reset
);
  // Idle link: clock stands still, strobes low, resets inactive
  initial
  begin
    lpc_clk        = 1'b0;
    stop_frame     = 1'b0;
    stop_quiet     = 1'b0;
    host_data_read = 1'b0;
    lpc_hw_reset_n = 1'b1;
    lpc_sw_reset   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One 160 ns link clock period carrying a stop frame or a host read
  task automatic frame(input logic sf, input logic q, input logic rd);
    @(posedge clock);
    stop_frame     <= sf;
    stop_quiet     <= q;
    host_data_read <= rd;
    repeat (16) @(posedge clock);
    lpc_clk <= 1'b1;
    repeat (16) @(posedge clock);
    lpc_clk <= 1'b0;
    repeat (16) @(posedge clock);
    stop_frame     <= 1'b0;
    host_data_read <= 1'b0;
    stop_quiet     <= ~q; // Released mode line shows the inverse, not the last value
  endtask

  // Pulse the hardware or the software LPC reset
  task automatic lpc_reset(input logic hw);
    @(posedge clock);
    if (hw)
      lpc_hw_reset_n <= 1'b0;
    else
      lpc_sw_reset <= 1'b1;
    repeat (8) @(posedge clock);
    lpc_hw_reset_n <= 1'b1;
    lpc_sw_reset   <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
endmodule // host_chipset_model

`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "serirq_params.svh"

module tb
  import serirq_pkg::*;
;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        lpc_clk, stop_frame, stop_quiet, host_data_read;
  logic        lpc_hw_reset_n, lpc_sw_reset;
  logic        host_smi_req, start_frame_req, irq;
  reg_byte_t   exp_q[$];
  reg_byte_t   d;
  int          n_fail = 0;
  int          tests_run = 0;
  int          n_pulse = 0;
  int          cycles = 0;
  int          seed = 73;

  // 200 MHz clock
  always #2.5 clock = ~clock;

  serirq_host_interrupt_control i_dut (
    .clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
    .waitrequest(waitrequest), .lpc_clk(lpc_clk), .stop_frame(stop_frame),
    .stop_quiet(stop_quiet), .host_data_read(host_data_read),
    .lpc_hw_reset_n(lpc_hw_reset_n), .lpc_sw_reset(lpc_sw_reset),
    .host_smi_req(host_smi_req), .start_frame_req(start_frame_req), .irq(irq));

  host_chipset_model i_host (
    .clock(clock), .lpc_clk(lpc_clk), .stop_frame(stop_frame), .stop_quiet(stop_quiet),
    .host_data_read(host_data_read), .lpc_hw_reset_n(lpc_hw_reset_n),
    .lpc_sw_reset(lpc_sw_reset));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // Counts, verdict, end of run
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One Avalon transfer; a read notes its expected byte
  task automatic bus(input logic wr, input logic [4:0] a, input reg_byte_t v);
    @(posedge clock);
    address   <= a;
    write     <= wr;
    read      <= ~wr;
    writedata <= {24'h0, v};
    if (!wr)
      exp_q.push_back(v);
    do
      @(posedge clock);
    while (waitrequest !== 1'b0);
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  // Check an output after its register lag has passed, sampled after the wait
  task automatic out_is(input string name, input logic exp);
    logic seen;
    repeat (3) @(posedge clock);
    if (name == "irq")
      seen = irq;
    else if (name == "host_smi_req")
      seen = host_smi_req;
    else
      seen = start_frame_req;
    chk(name, {31'h0, seen}, {31'h0, exp});
  endtask

  // Read data watcher: oldest note against the data at the answering edge
  always @(posedge clock)
  begin
    if (read && waitrequest === 1'b0 && exp_q.size() > 0)
      chk("readdata", readdata, {24'h0, exp_q.pop_front()});
  end

  // Start frame pulse counter and run ceiling
  always @(posedge clock)
  begin
    if (start_frame_req === 1'b1)
      n_pulse++;
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    repeat (10) @(posedge clock);
    bus(1'b1, `OFF_IRQ_CLR, 8'h0f);
    bus(1'b0, `OFF_IRQ_STAT, 8'h00);
    bus(1'b0, `OFF_CTRL0, 8'h00);
    bus(1'b0, `OFF_STATUS3, 8'h00);
    bus(1'b0, 5'h1c, 8'h00);
    // Mode capture and the mode event interrupt
    bus(1'b1, `OFF_IRQ_EN, 8'h01);
    i_host.frame(1'b1, 1'b1, 1'b0);
    bus(1'b0, `OFF_CTRL0, 8'h80);
    out_is("irq", 1'b1);
    bus(1'b1, `OFF_IRQ_CLR, 8'h01);
    out_is("irq", 1'b0);
    i_host.frame(1'b1, 1'b0, 1'b0);
    bus(1'b0, `OFF_CTRL0, 8'h00);
    // A control write disarms; write 1 without a fresh read is refused
    bus(1'b1, `OFF_CTRL0, 8'h00);
    bus(1'b1, `OFF_CTRL0, 8'h08);
    bus(1'b0, `OFF_CTRL0, 8'h00);
    bus(1'b1, `OFF_CTRL0, 8'h08);
    bus(1'b0, `OFF_CTRL0, 8'h08);
    out_is("host_smi_req", 1'b0);
    d = reg_byte_t'($random(seed));
    bus(1'b1, `OFF_ODATA3, d);
    out_is("host_smi_req", 1'b1);
    bus(1'b0, `OFF_ODATA3, d);
    bus(1'b0, `OFF_STATUS3, 8'h01);
    i_host.frame(1'b0, 1'b0, 1'b1);
    bus(1'b0, `OFF_STATUS3, 8'h00);
    bus(1'b0, `OFF_CTRL0, 8'h00);
    bus(1'b0, `OFF_IRQ_STAT, 8'h03);
    out_is("host_smi_req", 1'b0);
    // Source b through the two-way last byte, cleared by flag clear
    bus(1'b1, `OFF_CTRL0, 8'h10);
    d = reg_byte_t'($random(seed));
    bus(1'b1, `OFF_TWOWAY15, d);
    out_is("host_smi_req", 1'b1);
    bus(1'b0, `OFF_STATUS3, 8'h02);
    bus(1'b1, `OFF_STATUS3, 8'h00);
    bus(1'b0, `OFF_CTRL0, 8'h00);
    out_is("host_smi_req", 1'b0);
    // Flag a cleared by a written 0 also drops enable a in gated mode
    bus(1'b1, `OFF_CTRL0, 8'h08);
    d = reg_byte_t'($random(seed));
    bus(1'b1, `OFF_ODATA3, d);
    out_is("host_smi_req", 1'b1);
    bus(1'b1, `OFF_STATUS3, 8'h00);
    bus(1'b0, `OFF_STATUS3, 8'h00);
    bus(1'b0, `OFF_CTRL0, 8'h00);
    out_is("host_smi_req", 1'b0);
    // Direct mode: enable alone requests, written 0 clears
    bus(1'b1, `OFF_CTRL0, 8'h20);
    bus(1'b0, `OFF_CTRL0, 8'h20);
    bus(1'b1, `OFF_CTRL0, 8'h28);
    out_is("host_smi_req", 1'b1);
    bus(1'b1, `OFF_CTRL0, 8'h20);
    out_is("host_smi_req", 1'b0);
    bus(1'b0, `OFF_CTRL0, 8'h20);
    bus(1'b1, `OFF_CTRL0, 8'h30);
    out_is("host_smi_req", 1'b1);
    bus(1'b1, `OFF_CTRL0, 8'h20);
    out_is("host_smi_req", 1'b0);
    // Both LPC resets clear mode flag and enables, keep direct mode
    for (int hw = 0; hw < 2; hw++)
    begin
      i_host.frame(1'b1, 1'b1, 1'b0);
      bus(1'b0, `OFF_CTRL0, 8'ha0);
      bus(1'b1, `OFF_CTRL0, 8'ha8);
      i_host.lpc_reset(hw[0]);
      bus(1'b0, `OFF_CTRL0, 8'h20);
      out_is("host_smi_req", 1'b0);
    end
    // Start frame requests: none in continuous mode
    bus(1'b1, `OFF_CTRL0, 8'h38);
    bus(1'b1, `OFF_CTRL0, 8'h30);
    bus(1'b1, `OFF_CTRL0, 8'h20);
    out_is("start_frame_req", 1'b0);
    chk("pulse_count", n_pulse, 0);
    // Quiet, select 0: only when all clear
    i_host.frame(1'b1, 1'b1, 1'b0);
    bus(1'b0, `OFF_CTRL0, 8'ha0);
    bus(1'b1, `OFF_CTRL0, 8'hb8);
    bus(1'b1, `OFF_CTRL0, 8'hb0);
    out_is("start_frame_req", 1'b0);
    chk("pulse_count", n_pulse, 0);
    bus(1'b1, `OFF_CTRL0, 8'ha0);
    out_is("start_frame_req", 1'b0);
    chk("pulse_count", n_pulse, 1);
    // Quiet, select 1: any one clearing
    bus(1'b0, `OFF_CTRL0, 8'ha0);
    bus(1'b1, `OFF_CTRL0, 8'hf8);
    bus(1'b1, `OFF_CTRL0, 8'hf0);
    out_is("start_frame_req", 1'b0);
    chk("pulse_count", n_pulse, 2);
    bus(1'b0, `OFF_CTRL0, 8'hf0);
    // Let the watcher take the last answer, then no note may be left over
    repeat (2) @(posedge clock);
    chk("reads_left", exp_q.size(), 0);
    stop_test();
  end
endmodule // tb

`default_nettype wire
